// File: rtl/ddr3_mode_register_decode.sv
`timescale 1ns/1ps
`include "ddr_mode_defines.svh"
module ddr3_mode_register_decode
  import ddr_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ddr_ck_i,
  input wire logic ddr_reset_n_i,
  input wire logic ddr_cke_i,
  input wire logic ddr_cs_n_i,
  input wire logic ddr_ras_n_i,
  input wire logic ddr_cas_n_i,
  input wire logic ddr_we_n_i,
  input wire logic [2:0] ddr_ba_i,
  input wire logic [12:0] ddr_addr_i,
  output logic [2:0] burst_col_o,
  output logic burst_valid_o,
  output logic data_oe_o,
  output logic strobe_oe_o,
  output logic wr_internal_start_o,
  output logic dll_reset_o,
  output logic dll_frozen_o,
  output logic exit_wait_o,
  output logic test_mode_o,
  output logic interleave_o,
  output logic [4:0] cas_latency_o,
  output logic [5:0] read_latency_o,
  output logic [2:0] write_recovery_o
);
  localparam int PIN_W = 23;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic ck_prev_q;
  logic ck_rise;
  logic ck_edge;
  logic s_reset_n;
  logic s_cke;
  logic s_cs_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_we_n;
  logic [2:0] s_ba;
  logic [12:0] s_addr;

  logic cmd_valid;
  logic cmd_mrs;
  logic cmd_mr0;
  logic cmd_mr1;
  logic cmd_read;
  logic cmd_write;
  logic cmd_nop;

  logic [`MR_WIDTH-1:0] mr0_q;
  logic [`MR_WIDTH-1:0] mr1_q;
  logic [9:0] dll_cnt_q;
  logic [4:0] since_mrs_q;
  logic mrs_seen_q;
  logic cke_prev_q;
  logic pd_q;
  logic [4:0] exit_cnt_q;
  logic [2:0] ctrl_q;
  logic [3:0] err_q;
  logic [3:0] err_set;
  logic [3:0] err_clr;

  burst_state_type state_q;
  logic [5:0] lat_cnt_q;
  logic cmd_write_q;
  logic cmd_chop_q;
  logic [2:0] cmd_col_q;
  logic seq_load;
  logic seq_busy;
  logic [4:0] wr_int_cnt_q;
  logic wr_int_run_q;

  bl_mode_type bl_mode;
  logic [4:0] cl;
  logic [5:0] al;
  logic [5:0] rl;
  logic chop_now;
  logic [2:0] seq_col;
  logic seq_valid;
  logic seq_oe;

  logic apb_setup;
  logic apb_write;
  logic [31:0] rdata_d;
  logic addr_hit;

  // pin synchroniser and link clock edges
  assign pins_raw = {ddr_ck_i, ddr_reset_n_i, ddr_cke_i, ddr_cs_n_i, ddr_ras_n_i,
                     ddr_cas_n_i, ddr_we_n_i, ddr_ba_i, ddr_addr_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ck_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      ck_prev_q <= sync2_q[PIN_W-1];
    end
  end

  assign {s_reset_n, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr} = sync2_q[PIN_W-2:0];
  assign ck_rise = sync2_q[PIN_W-1] && !ck_prev_q;
  assign ck_edge = sync2_q[PIN_W-1] != ck_prev_q;

  // command decode on the rising link clock edge
  assign cmd_valid = ck_rise && s_reset_n && s_cke && !s_cs_n && ctrl_q[`CTRL_ENABLE_BIT];
  assign cmd_mrs = cmd_valid && !s_ras_n && !s_cas_n && !s_we_n;
  assign cmd_mr0 = cmd_mrs && (s_ba == 3'h0);
  assign cmd_mr1 = cmd_mrs && (s_ba == 3'h1);
  assign cmd_read = cmd_valid && s_ras_n && !s_cas_n && s_we_n;
  assign cmd_write = cmd_valid && s_ras_n && !s_cas_n && !s_we_n;
  assign cmd_nop = cmd_valid && s_ras_n && s_cas_n && s_we_n;

  // mode field decode
  assign bl_mode = bl_mode_type'(mr0_q[`MR_BL_LSB +: 2]);
  assign cl = 5'({1'b0, mr0_q[`MR_CL_LOW_BIT], mr0_q[`MR_CL_LSB +: 3]} + `CL_BASE);
  always_comb begin
    unique case (ctrl_q[`CTRL_AL_LSB +: 2])
      2'h1: al = 6'({1'b0, cl} - 6'h01);
      2'h2: al = 6'({1'b0, cl} - 6'h02);
      default: al = 6'h00;
    endcase
  end
  assign rl = 6'(al + {1'b0, cl});

  always_comb begin
    unique case (bl_mode)
      BL_FIXED4: chop_now = 1'b1;
      BL_OTF: chop_now = !s_addr[`MR_BC_N_BIT];
      default: chop_now = 1'b0;
    endcase
  end

  // mode registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mr0_q <= '0;
      mr1_q <= '0;
    end else if (!s_reset_n) begin
      mr0_q <= '0;
      mr1_q <= '0;
    end else begin
      if (cmd_mr0) begin
        mr0_q <= s_addr;
      end else if (dll_cnt_q == 10'h001 && ck_rise) begin
        mr0_q[`MR_DLL_RST_BIT] <= 1'b0;
      end
      if (cmd_mr1) begin
        mr1_q <= s_addr;
      end
    end
  end

  // dll reset run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dll_cnt_q <= 10'h000;
    end else if (!s_reset_n) begin
      dll_cnt_q <= 10'h000;
    end else if (cmd_mr0 && s_addr[`MR_DLL_RST_BIT]) begin
      dll_cnt_q <= `DLL_RESET_CK;
    end else if (ck_rise && dll_cnt_q != 10'h000) begin
      dll_cnt_q <= 10'(dll_cnt_q - 10'h001);
    end
  end

  // spacing since last mode register set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_mrs_q <= 5'h00;
      mrs_seen_q <= 1'b0;
    end else if (cmd_mrs) begin
      since_mrs_q <= 5'h00;
      mrs_seen_q <= 1'b1;
    end else if (ck_rise && since_mrs_q != 5'h1F) begin
      since_mrs_q <= 5'(since_mrs_q + 5'h01);
    end
  end

  // protocol error detection
  always_comb begin
    err_set = 4'h0;
    err_set[`ST_TMOD_ERR_BIT] = mrs_seen_q && cmd_valid && !cmd_mrs && !cmd_nop
                                && (since_mrs_q < 5'(`TMOD_CK - 5'h01));
    err_set[`ST_TMRD_ERR_BIT] = mrs_seen_q && cmd_mrs
                                && (since_mrs_q < 5'(`TMRD_CK - 5'h01));
    err_set[`ST_RSVD_ERR_BIT] = cmd_mr0 && (s_addr[`MR_BL_LSB +: 2] == BL_RSVD);
    err_set[`ST_BUSY_ERR_BIT] = cmd_mrs && (state_q != RD_IDLE || seq_busy);
  end

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pready_o && pwrite_i;
  assign err_clr = (apb_write && paddr_i == `REG_STATUS_OFFSET && pstrb_i[0]) ? pwdata_i[3:0] : 4'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // precharge power-down tracking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_prev_q <= 1'b0;
      pd_q <= 1'b0;
      exit_cnt_q <= 5'h00;
    end else if (ck_rise) begin
      cke_prev_q <= s_cke;
      if (cke_prev_q && !s_cke && state_q == RD_IDLE && !seq_busy) begin
        pd_q <= 1'b1;
      end else if (pd_q && s_cke) begin
        pd_q <= 1'b0;
        exit_cnt_q <= mr0_q[`MR_PPD_BIT] ? `TXP_CK : `TXPDLL_CK;
      end else if (exit_cnt_q != 5'h00) begin
        exit_cnt_q <= 5'(exit_cnt_q - 5'h01);
      end
    end
  end

  // burst scheduling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= RD_IDLE;
      lat_cnt_q <= 6'h00;
      cmd_write_q <= 1'b0;
      cmd_chop_q <= 1'b0;
      cmd_col_q <= 3'h0;
    end else begin
      unique case (state_q)
        RD_IDLE: begin
          if (cmd_read || cmd_write) begin
            state_q <= RD_WAIT;
            lat_cnt_q <= cmd_write ? 6'(al + `WRITE_LATENCY_CK) : rl;
            cmd_write_q <= cmd_write;
            cmd_chop_q <= chop_now;
            cmd_col_q <= s_addr[2:0];
          end
        end
        RD_WAIT: begin
          if (ck_rise) begin
            if (lat_cnt_q <= 6'h01) begin
              state_q <= RD_BURST;
            end else begin
              lat_cnt_q <= 6'(lat_cnt_q - 6'h01);
            end
          end
        end
        RD_BURST: begin
          if (!seq_busy && !seq_load) begin
            state_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  assign seq_load = (state_q == RD_WAIT) && ck_rise && (lat_cnt_q <= 6'h01);

  burst_sequencer u_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(seq_load),
    .step_i(ck_edge),
    .is_write_i(cmd_write_q),
    .chop_i(cmd_chop_q),
    .interleave_i(mr0_q[`MR_BT_BIT]),
    .start_col_i(cmd_col_q),
    .col_o(seq_col),
    .valid_o(seq_valid),
    .oe_o(seq_oe),
    .busy_o(seq_busy)
  );

  // internal write start, pulled in for fixed chop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_int_cnt_q <= 5'h00;
      wr_int_run_q <= 1'b0;
      wr_internal_start_o <= 1'b0;
    end else begin
      wr_internal_start_o <= 1'b0;
      if (cmd_write && !wr_int_run_q) begin
        wr_int_run_q <= 1'b1;
        if (bl_mode == BL_FIXED4) begin
          wr_int_cnt_q <= 5'(`WRITE_INTERNAL_CK - `FIXED_CHOP_PULL_IN);
        end else begin
          wr_int_cnt_q <= `WRITE_INTERNAL_CK;
        end
      end else if (wr_int_run_q && ck_rise) begin
        if (wr_int_cnt_q <= 5'h01) begin
          wr_int_run_q <= 1'b0;
          wr_internal_start_o <= 1'b1;
        end else begin
          wr_int_cnt_q <= 5'(wr_int_cnt_q - 5'h01);
        end
      end
    end
  end

  // registered user outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_col_o <= 3'h0;
      burst_valid_o <= 1'b0;
      data_oe_o <= 1'b0;
      strobe_oe_o <= 1'b0;
      dll_reset_o <= 1'b0;
      dll_frozen_o <= 1'b0;
      exit_wait_o <= 1'b0;
      test_mode_o <= 1'b0;
      interleave_o <= 1'b0;
      cas_latency_o <= 5'h00;
      read_latency_o <= 6'h00;
      write_recovery_o <= 3'h0;
    end else begin
      burst_col_o <= seq_col;
      burst_valid_o <= seq_valid;
      data_oe_o <= seq_oe;
      strobe_oe_o <= seq_oe;
      dll_reset_o <= dll_cnt_q != 10'h000;
      dll_frozen_o <= pd_q && !mr0_q[`MR_PPD_BIT];
      exit_wait_o <= exit_cnt_q != 5'h00;
      test_mode_o <= mr0_q[`MR_TM_BIT];
      interleave_o <= mr0_q[`MR_BT_BIT];
      cas_latency_o <= cl;
      read_latency_o <= rl;
      write_recovery_o <= mr0_q[`MR_WR_LSB +: 3];
    end
  end

  // apb slave
  assign addr_hit = (paddr_i == `REG_CTRL_OFFSET) || (paddr_i == `REG_STATUS_OFFSET)
                    || (paddr_i == `REG_MR0_OFFSET) || (paddr_i == `REG_MR1_OFFSET)
                    || (paddr_i == `REG_LATENCY_OFFSET);

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr_i)
      `REG_CTRL_OFFSET: rdata_d[2:0] = ctrl_q;
      `REG_STATUS_OFFSET: begin
        rdata_d[3:0] = err_q;
        rdata_d[`ST_DLL_BUSY_BIT] = dll_cnt_q != 10'h000;
        rdata_d[`ST_PD_BIT] = pd_q;
        rdata_d[`ST_EXIT_WAIT_BIT] = exit_cnt_q != 5'h00;
        rdata_d[`ST_BURST_BUSY_BIT] = (state_q != RD_IDLE) || seq_busy;
      end
      `REG_MR0_OFFSET: rdata_d[`MR_WIDTH-1:0] = mr0_q;
      `REG_MR1_OFFSET: rdata_d[`MR_WIDTH-1:0] = mr1_q;
      `REG_LATENCY_OFFSET: begin
        rdata_d[4:0] = cl;
        rdata_d[13:8] = rl;
        rdata_d[18:16] = mr0_q[`MR_WR_LSB +: 3];
        rdata_d[21:20] = mr0_q[`MR_BL_LSB +: 2];
        rdata_d[24] = mr0_q[`MR_BT_BIT];
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !addr_hit;
      if (apb_setup && !pwrite_i) begin
        prdata_o <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `CTRL_RESET_VALUE;
    end else if (apb_write && paddr_i == `REG_CTRL_OFFSET && pstrb_i[0]) begin
      ctrl_q <= pwdata_i[2:0];
    end
  end
endmodule

// File: rtl/ddr_mode_defines.svh
// Contract
// - MR0 write: all command and bank lines low
// - write recovery from A9..A11 sets tDAL
// - CAS latency from A2 and A4..A6
// - read latency equals additive plus CAS latency
// - A7 selects test mode, keep zero
// - A3 selects sequential or interleaved burst
// - A0..A1 select chop-4, burst-8 or on-the-fly
// - on-the-fly: A12 picks chop per command
// - read order from start column, sequential or XOR
// - chop-4 read: four beats, then drivers off
// - writes ascending; chop uses A2, burst-8 column 0
// - fixed chop-4 write starts two clocks earlier
// - DLL reset bit clears itself when done
// - A12 zero: DLL frozen, tXPDLL exit wait
// - A12 one: DLL kept, tXP exit wait
// - MR1 write: BA0 high, others low
// - MR0 write with A8 high starts DLL reset
`ifndef DDR_MODE_DEFINES_SVH
`define DDR_MODE_DEFINES_SVH

`define REG_CTRL_OFFSET 12'h000
`define REG_STATUS_OFFSET 12'h004
`define REG_MR0_OFFSET 12'h008
`define REG_MR1_OFFSET 12'h00C
`define REG_LATENCY_OFFSET 12'h010

`define CTRL_AL_LSB 0
`define CTRL_ENABLE_BIT 2
`define CTRL_RESET_VALUE 3'h4

`define ST_TMOD_ERR_BIT 0
`define ST_TMRD_ERR_BIT 1
`define ST_RSVD_ERR_BIT 2
`define ST_BUSY_ERR_BIT 3
`define ST_DLL_BUSY_BIT 8
`define ST_PD_BIT 9
`define ST_EXIT_WAIT_BIT 10
`define ST_BURST_BUSY_BIT 11

`define MR_WIDTH 13
`define MR_BL_LSB 0
`define MR_CL_LOW_BIT 2
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_TM_BIT 7
`define MR_DLL_RST_BIT 8
`define MR_WR_LSB 9
`define MR_PPD_BIT 12
`define MR_BC_N_BIT 12
`define CL_BASE 5'h04

`define TMOD_CK 5'h0C
`define TMRD_CK 5'h04
`define DLL_RESET_CK 10'h200
`define TXP_CK 5'h03
`define TXPDLL_CK 5'h0A
`define WRITE_LATENCY_CK 6'h05
`define WRITE_INTERNAL_CK 5'h0A
`define FIXED_CHOP_PULL_IN 5'h02

`endif

// File: rtl/ddr_mode_pkg.sv
package ddr_mode_pkg;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_BURST = 3'b100
  } burst_state_type;
  typedef enum logic [1:0] {
    BL_FIXED8 = 2'b00,
    BL_OTF = 2'b01,
    BL_FIXED4 = 2'b10,
    BL_RSVD = 2'b11
  } bl_mode_type;
endpackage

// File: rtl/burst_sequencer.sv
`timescale 1ns/1ps
module burst_sequencer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic is_write_i,
  input wire logic chop_i,
  input wire logic interleave_i,
  input wire logic [2:0] start_col_i,
  output logic [2:0] col_o,
  output logic valid_o,
  output logic oe_o,
  output logic busy_o
);
  logic [2:0] idx_q;
  logic [2:0] start_q;
  logic write_q;
  logic chop_q;
  logic ilv_q;
  logic [2:0] col_d;

  always_comb begin
    if (ilv_q && !write_q) begin
      col_d = start_q ^ idx_q;
    end else begin
      col_d = {start_q[2] ^ idx_q[2], 2'(start_q[1:0] + idx_q[1:0])};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q <= 3'h0;
      start_q <= 3'h0;
      write_q <= 1'b0;
      chop_q <= 1'b0;
      ilv_q <= 1'b0;
      busy_o <= 1'b0;
    end else if (load_i) begin
      idx_q <= 3'h0;
      write_q <= is_write_i;
      chop_q <= chop_i;
      ilv_q <= interleave_i;
      busy_o <= 1'b1;
      if (is_write_i) begin
        start_q <= chop_i ? {start_col_i[2], 2'h0} : 3'h0;
      end else begin
        start_q <= start_col_i;
      end
    end else if (step_i && busy_o) begin
      idx_q <= 3'(idx_q + 3'h1);
      if (idx_q == 3'h7) begin
        busy_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_o <= 3'h0;
      valid_o <= 1'b0;
      oe_o <= 1'b0;
    end else if (step_i) begin
      col_o <= col_d;
      valid_o <= busy_o && !(chop_q && idx_q[2]);
      oe_o <= busy_o && !write_q && !(chop_q && idx_q[2]);
    end
  end
endmodule

// File: testbench/ddr3_mode_register_decode_monitor.sv
`timescale 1ns/1ps
module ddr3_mode_register_decode_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic ddr_reset_n_i,
  input wire logic ddr_cs_n_i,
  input wire logic ddr_ras_n_i,
  input wire logic ddr_cas_n_i,
  input wire logic ddr_we_n_i,
  input wire logic burst_valid_o,
  input wire logic data_oe_o,
  input wire logic strobe_oe_o,
  input wire logic wr_internal_start_o,
  input wire logic dll_reset_o,
  input wire logic exit_wait_o,
  input wire logic test_mode_o,
  input wire logic interleave_o,
  input wire logic [4:0] cas_latency_o,
  input wire logic [2:0] write_recovery_o
);
  logic [5:0] oe_q;
  logic [12:0] dll_q;
  logic [6:0] ew_q;
  logic [5:0] age_q;
  logic [9:0] mode_w;
  assign mode_w = {test_mode_o, interleave_o, cas_latency_o, write_recovery_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // run lengths
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) oe_q <= 6'h00;
    else oe_q <= data_oe_o ? oe_q + 6'h01 : 6'h00;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) dll_q <= 13'h0000;
    else dll_q <= dll_reset_o ? dll_q + 13'h0001 : 13'h0000;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) ew_q <= 7'h00;
    else ew_q <= exit_wait_o ? ew_q + 7'h01 : 7'h00;
  // cycles since mrs or pin reset
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) age_q <= 6'h00;
    else if (!(ddr_cs_n_i | ddr_ras_n_i | ddr_cas_n_i | ddr_we_n_i) || !ddr_reset_n_i) age_q <= 6'h00;
    else if (age_q != 6'h3F) age_q <= age_q + 6'h01;
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i && pready_o; endsequence
  a_apb_answer: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_oe_pair: assert property (data_oe_o == strobe_oe_o)
    else $error("data and strobe enables differ");
  a_oe_beat: assert property (data_oe_o |-> burst_valid_o)
    else $error("driver on in empty slot");
  a_read_slots: assert property ($fell(data_oe_o) |-> oe_q inside {[6'h0F:6'h11], [6'h1F:6'h21]})
    else $error("read driver run length wrong");
  a_wr_pulse: assert property (wr_internal_start_o |=> !wr_internal_start_o)
    else $error("write start not a pulse");
  a_dll_clear: assert property (dll_reset_o |-> dll_q < 13'h10CC)
    else $error("dll reset never clears");
  a_dll_cause: assert property ($rose(dll_reset_o) |-> age_q < 6'h18)
    else $error("dll reset without mrs");
  a_mode_cause: assert property ($changed(mode_w) |-> age_q < 6'h18)
    else $error("mode output changed without mrs");
  a_exit_len: assert property (exit_wait_o |-> ew_q < 7'h54)
    else $error("exit wait too long");
endmodule
bind ddr3_mode_register_decode ddr3_mode_register_decode_monitor u_mon (.clk_i, .rst_n_i, .psel_i,
  .penable_i, .pready_o, .ddr_reset_n_i, .ddr_cs_n_i, .ddr_ras_n_i, .ddr_cas_n_i, .ddr_we_n_i,
  .burst_valid_o, .data_oe_o, .strobe_oe_o, .wr_internal_start_o, .dll_reset_o, .exit_wait_o,
  .test_mode_o, .interleave_o, .cas_latency_o, .write_recovery_o);

// File: testbench/ddr_ctrl_model.sv
`timescale 1ns/1ps
module ddr_ctrl_model (
  output logic ck_o,
  output logic reset_n_o,
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [2:0] ba_o,
  output logic [12:0] addr_o
);
  initial begin
    ck_o = 1'b0;
    reset_n_o = 1'b1;
    cke_o = 1'b1;
    cmd_o = 4'hF;
    ba_o = 3'h0;
    addr_o = 13'h0000;
  end
  always #32 ck_o = ~ck_o;
  // idle slots, stale lines scrambled
  task automatic nop(input int n);
    repeat (n) begin
      @(negedge ck_o);
      cmd_o = 4'h7;
      ba_o = ~ba_o;
      addr_o = ~addr_o;
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(negedge ck_o);
    cmd_o = c;
    ba_o = b;
    addr_o = a;
    nop(1);
  endtask
  task automatic mrs(input logic [2:0] b, input logic [12:0] a);
    wait (cke_o === 1'b1);
    issue(4'h0, b, a);
    nop(12);
  endtask
  task automatic set_cke(input logic v);
    @(negedge ck_o);
    cke_o = v;
  endtask
endmodule

// File: testbench/ddr3_mode_register_decode_bench.sv
`timescale 1ns/1ps
`include "ddr_mode_defines.svh"
module ddr3_mode_register_decode_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, burst_valid_o, data_oe_o, strobe_oe_o, wr_internal_start_o;
  logic dll_reset_o, dll_frozen_o, exit_wait_o, test_mode_o, interleave_o, ck, rn, cke, lv;
  logic [2:0] burst_col_o, write_recovery_o, ba, lc;
  logic [4:0] cas_latency_o;
  logic [5:0] read_latency_o;
  logic [3:0] cmd;
  logic [12:0] ad;
  logic [2:0] q[$];
  int n_errors = 0, compares = 0, oe_n = 0, cyc = 0;
  time ti, tw;
  always #4 clk_i = ~clk_i;
  ddr_ctrl_model u_ctrl (.ck_o(ck), .reset_n_o(rn), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(ad));
  ddr3_mode_register_decode u_dut (.clk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .ddr_ck_i(ck), .ddr_reset_n_i(rn), .ddr_cke_i(cke),
    .ddr_cs_n_i(cmd[3]), .ddr_ras_n_i(cmd[2]), .ddr_cas_n_i(cmd[1]), .ddr_we_n_i(cmd[0]), .ddr_ba_i(ba),
    .ddr_addr_i(ad), .burst_col_o, .burst_valid_o, .data_oe_o, .strobe_oe_o, .wr_internal_start_o,
    .dll_reset_o, .dll_frozen_o, .exit_wait_o, .test_mode_o, .interleave_o, .cas_latency_o,
    .read_latency_o, .write_recovery_o);
  // beat capture and timeout
  always @(posedge clk_i) begin
    if (burst_valid_o === 1'b1 && !(lv === 1'b1 && lc === burst_col_o)) q.push_back(burst_col_o);
    lv = burst_valid_o;
    lc = burst_col_o;
    oe_n += (data_oe_o === 1'b1);
    if (wr_internal_start_o === 1'b1) tw = $time;
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    r = {prdata_o[31:1], prdata_o[0] | (pslverr_o === 1'b1 && a == 12'h020)};
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic [2:0] beat(logic [2:0] s, logic il, int i);
    logic [2:0] k;
    k = i[2:0];
    return il ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction
  task automatic t_regs;
    logic [31:0] r;
    apb(1'b0, `REG_CTRL_OFFSET, 32'h0, r);
    chk(r, `CTRL_RESET_VALUE);
    apb(1'b0, 12'h020, 32'h0, r);
    chk(r, 32'h1);
    u_ctrl.mrs(3'h0, 13'h0003);
    apb(1'b0, `REG_STATUS_OFFSET, 32'h0, r);
    chk(r[`ST_RSVD_ERR_BIT], 1'b1);
    apb(1'b1, `REG_STATUS_OFFSET, 32'h4, r);
    apb(1'b0, `REG_STATUS_OFFSET, 32'h0, r);
    chk(r[`ST_RSVD_ERR_BIT], 1'b0);
  endtask
  task automatic t_mr0;
    logic [12:0] v[3];
    logic [31:0] r;
    v = '{13'h1E7C, 13'h0210, 13'h0084};
    foreach (v[i]) begin
      u_ctrl.mrs(3'h0, v[i]);
      chk(cas_latency_o, {v[i][2], v[i][6:4]} + 5'h04);
      chk(read_latency_o, {v[i][2], v[i][6:4]} + 6'h04);
      chk(write_recovery_o, v[i][11:9]);
      chk(interleave_o, v[i][3]);
      chk(test_mode_o, v[i][7]);
      apb(1'b0, `REG_MR0_OFFSET, 32'h0, r);
      chk(r, v[i]);
    end
    u_ctrl.mrs(3'h1, 13'h0044);
    apb(1'b0, `REG_MR1_OFFSET, 32'h0, r);
    chk(r, 32'h44);
    apb(1'b0, `REG_MR0_OFFSET, 32'h0, r);
    chk(r, 32'h84);
    apb(1'b1, `REG_CTRL_OFFSET, 32'h5, r);
    repeat (3) @(posedge clk_i);
    chk(read_latency_o, 32'h17);
    apb(1'b1, `REG_CTRL_OFFSET, 32'h6, r);
    repeat (3) @(posedge clk_i);
    chk(read_latency_o, 32'h16);
    apb(1'b0, `REG_LATENCY_OFFSET, 32'h0, r);
    chk(r, 32'h0000_160C);
    apb(1'b1, `REG_CTRL_OFFSET, 32'h4, r);
  endtask
  task automatic t_dll;
    logic [31:0] r;
    int n;
    u_ctrl.mrs(3'h0, 13'h0100);
    chk(dll_reset_o, 1'b1);
    apb(1'b0, `REG_MR0_OFFSET, 32'h0, r);
    chk(r, 32'h100);
    apb(1'b0, `REG_STATUS_OFFSET, 32'h0, r);
    chk(r[`ST_DLL_BUSY_BIT], 1'b1);
    n = 0;
    while (dll_reset_o !== 1'b0 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    apb(1'b0, `REG_MR0_OFFSET, 32'h0, r);
    chk(r, 32'h0);
  endtask
  task automatic t_burst(input logic [12:0] mr, input logic [3:0] c, input logic [12:0] a, input int n,
    input logic il);
    int o;
    u_ctrl.mrs(3'h0, mr);
    q.delete();
    o = oe_n;
    u_ctrl.issue(c, 3'h0, a);
    ti = $time;
    u_ctrl.nop(40);
    chk(q.size(), n);
    foreach (q[i]) chk(q[i], c[0] ? beat(a[2:0], il, i) : {a[2] & (n == 4), 2'b00} + 3'(i));
    chk(oe_n != o, c[0]);
  endtask
  task automatic t_pull;
    time d;
    t_burst(13'h0002, 4'h4, 13'h0004, 4, 1'b0);
    d = tw - ti;
    t_burst(13'h0001, 4'h4, 13'h0004, 4, 1'b0);
    chk(32'((tw - ti - d + 32) / 64), 32'h2);
  endtask
  task automatic t_pd;
    int n;
    for (int p = 0; p < 2; p++) begin
      u_ctrl.mrs(3'h0, {p[0], 12'h000});
      u_ctrl.set_cke(1'b0);
      u_ctrl.nop(4);
      chk(dll_frozen_o, !p[0]);
      u_ctrl.set_cke(1'b1);
      n = 0;
      repeat (200) begin
        @(posedge clk_i);
        n += (exit_wait_o === 1'b1);
      end
      chk(32'((n + 4) / 8), p[0] ? `TXP_CK : `TXPDLL_CK);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    u_ctrl.nop(2);
    t_regs();
    t_mr0();
    t_dll();
    t_burst(13'h0000, 4'h5, 13'h0005, 8, 1'b0);
    t_burst(13'h0008, 4'h5, 13'h0006, 8, 1'b1);
    t_burst(13'h000A, 4'h5, 13'h0005, 4, 1'b1);
    t_burst(13'h0001, 4'h5, 13'h1003, 8, 1'b0);
    t_burst(13'h0001, 4'h5, 13'h0003, 4, 1'b0);
    t_burst(13'h0000, 4'h4, 13'h0007, 8, 1'b0);
    t_pull();
    t_pd();
    report_and_stop();
  end
endmodule
